// *** src/sasq_defs.vh ***
// register indices, field positions and bus codes of the converter sequencer
// assumes inclusion by bare name from each design file
`ifndef SASQ_DEFS_VH
`define SASQ_DEFS_VH

`define SASQ_AXI_AW        18
`define SASQ_IDX_W         16
`define SASQ_IDX_CH6_LOW   16'hf2dc
`define SASQ_IDX_CH6_HIGH  16'hf2dd
`define SASQ_IDX_CH7_LOW   16'hf2de
`define SASQ_IDX_CH7_HIGH  16'hf2df
`define SASQ_IDX_LOOP      16'hf2f0
`define SASQ_IDX_RUN       16'hf2f1
`define SASQ_IDX_MASK      16'hf2f2
`define SASQ_IDX_IRQ_STAT  16'hf2f4
`define SASQ_IDX_IRQ_EN    16'hf2f5
`define SASQ_IDX_IRQ_CLR   16'hf2f6
`define SASQ_IDX_SEQ_STATE 16'hf2f7

`define SASQ_LOOP_BIT      0
`define SASQ_RUN_BIT       0
`define SASQ_DONE_EVT      0
`define SASQ_BUSY_BIT      3
`define SASQ_RESET_BYTE    8'h00
`define SASQ_RES_W         10
`define SASQ_NUM_CH        8
`define SASQ_CH_W          3
`define SASQ_FIRST_KEPT_CH 3'h6
`define SASQ_KEPT_CH       2
`define SASQ_RESP_OKAY     2'b00
`define SASQ_RESP_SLVERR   2'b10

`endif

// *** src/sasq_irq.v ***
// sticky event status, enable mask and level interrupt
// assumes events are one-cycle pulses in the aclk domain
`timescale 1ns/10ps
`default_nettype none
`include "sasq_defs.vh"

module sasq_irq #(
	parameter N = 1
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [N-1:0] event_in,
	input  wire         en_we,
	input  wire [N-1:0] en_wdata,
	input  wire         clr_we,
	input  wire [N-1:0] clr_wdata,
	output reg  [N-1:0] status_q,
	output reg  [N-1:0] enable_q,
	output reg          irq_q
);
	wire [N-1:0] clr_mask;
	wire [N-1:0] status_d;

	assign clr_mask = clr_we ? clr_wdata : {N{1'b0}};
	// a new event beats a clear in the same cycle
	assign status_d = (status_q & ~clr_mask) | event_in;

	always @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= {N{1'b0}};
			enable_q <= {N{1'b0}};
			irq_q    <= 1'b0;
		end else begin
			status_q <= status_d;
			if (en_we) begin
				enable_q <= en_wdata;
			end
			irq_q <= |(status_d & (en_we ? en_wdata : enable_q));
		end
	end
endmodule // sasq_irq

`default_nettype wire

// *** src/sasq_seq.v ***
// channel sequencer: walks the captured mask upward, one conversion at a time
// assumes the core answers each start with exactly one done pulse
`timescale 1ns/10ps
`default_nettype none
`include "sasq_defs.vh"

module sasq_seq #(
	parameter NCH = `SASQ_NUM_CH,
	parameter CW  = `SASQ_CH_W
) (
	input  wire           aclk,
	input  wire           aresetn,
	input  wire           start,
	input  wire           stop,
	input  wire           loop_sel,
	input  wire [NCH-1:0] mask,
	input  wire           conv_done,
	output reg            conv_start_q,
	output reg  [CW-1:0]  conv_chan_q,
	output wire           res_we,
	output reg            seq_done_q,
	output reg            run_clear_q,
	output wire           busy
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_ISSUE = 2'd1;
	localparam ST_WAIT  = 2'd2;

	reg [1:0]     state_q;
	reg [NCH-1:0] mask_cap_q;
	wire [CW:0]   next_hit;
	wire [CW:0]   first_new;

	// lowest enabled channel at or above 'from'; msb flags a hit
	function [CW:0] first_from;
		input [NCH-1:0] m;
		input [CW:0]    from;
		integer         i;
		begin
			first_from = {(CW+1){1'b0}};
			for (i = NCH - 1; i >= 0; i = i - 1) begin
				if (m[i] && (i >= from)) begin
					first_from = {1'b1, i[CW-1:0]};
				end
			end
		end
	endfunction

	assign next_hit  = first_from(mask_cap_q, {1'b0, conv_chan_q} + 1'b1);
	assign first_new = first_from(mask, {(CW+1){1'b0}});
	// an abort in the same cycle as done discards that result
	assign res_we = (state_q == ST_WAIT) && conv_done && !stop;
	assign busy   = (state_q != ST_IDLE);

	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q      <= ST_IDLE;
			mask_cap_q   <= {NCH{1'b0}};
			conv_chan_q  <= {CW{1'b0}};
			conv_start_q <= 1'b0;
			seq_done_q   <= 1'b0;
			run_clear_q  <= 1'b0;
		end else begin
			conv_start_q <= 1'b0;
			seq_done_q   <= 1'b0;
			run_clear_q  <= 1'b0;
			if (stop) begin
				state_q <= ST_IDLE;
			end else begin
				case (state_q)
				ST_IDLE: begin
					if (start && first_new[CW]) begin
						mask_cap_q  <= mask;
						conv_chan_q <= first_new[CW-1:0];
						state_q     <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					conv_start_q <= 1'b1;
					state_q      <= ST_WAIT;
				end
				ST_WAIT: begin
					if (conv_done) begin
						if (next_hit[CW]) begin
							conv_chan_q <= next_hit[CW-1:0];
							state_q     <= ST_ISSUE;
						end else begin
							seq_done_q <= 1'b1;
							if (loop_sel && first_new[CW]) begin
								// mask edits only count from here on
								mask_cap_q  <= mask;
								conv_chan_q <= first_new[CW-1:0];
								state_q     <= ST_ISSUE;
							end else begin
								run_clear_q <= 1'b1;
								state_q     <= ST_IDLE;
							end
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule // sasq_seq

`default_nettype wire

// *** src/sasq_top.v ***
// converter sequencer control: axi4-lite registers, run logic, results 6 and 7
// assumes one aclk domain and an external converter core on the conv_* pins
`timescale 1ns/10ps
`default_nettype none
`include "sasq_defs.vh"

// What this block does
// - low byte bits 7:6 hold result bits 1:0
// - high byte holds result bits 9:2
// - results read-only, reset zero, load on completion
// - low result allows 16-bit read of pair
// - loop bit picks single or continuous mode
// - single mode clears run after last channel
// - run bit: write 1 starts, 0 stops
// - mask bit n enables channel n
// - enabled channels convert in ascending order
// - run with empty mask: nothing, reads 0
// - control and mask registers read/write, reset zero
// - continuous mode restarts until run cleared
// - completion interrupt after last selected channel
// - mask captured at start until completion
module sasq_top #(
	parameter AW  = `SASQ_AXI_AW,
	parameter NCH = `SASQ_NUM_CH,
	parameter CW  = `SASQ_CH_W,
	parameter RW  = `SASQ_RES_W
) (
	input  wire          aclk,
	input  wire          aresetn,
	input  wire [AW-1:0] s_axi_awaddr,
	input  wire [2:0]    s_axi_awprot,
	input  wire          s_axi_awvalid,
	output reg           s_axi_awready,
	input  wire [31:0]   s_axi_wdata,
	input  wire [3:0]    s_axi_wstrb,
	input  wire          s_axi_wvalid,
	output reg           s_axi_wready,
	output reg  [1:0]    s_axi_bresp,
	output reg           s_axi_bvalid,
	input  wire          s_axi_bready,
	input  wire [AW-1:0] s_axi_araddr,
	input  wire [2:0]    s_axi_arprot,
	input  wire          s_axi_arvalid,
	output reg           s_axi_arready,
	output reg  [31:0]   s_axi_rdata,
	output reg  [1:0]    s_axi_rresp,
	output reg           s_axi_rvalid,
	input  wire          s_axi_rready,
	output wire          conv_start,
	output wire [CW-1:0] conv_chan,
	input  wire          conv_done,
	input  wire [RW-1:0] conv_data,
	output wire          conversion_done_irq
);
	////////////////////////////////////////////////////////////////////////////////
	// declarations

	reg  [AW-1:0]  aw_addr_q;
	reg            aw_have_q;
	reg  [31:0]    w_data_q;
	reg  [3:0]     w_strb_q;
	reg            w_have_q;
	reg            continuous_select_q;
	reg            run_bit_q;
	reg  [NCH-1:0] channel_select_mask_q;
	reg  [RW-1:0]  kept_res_q [0:`SASQ_KEPT_CH-1];
	reg  [31:0]    rd_word;
	reg            run_d;

	wire           wr_fire;
	wire [15:0]    wr_idx;
	wire [15:0]    rd_idx;
	wire           run_wr;
	wire           run_wval;
	wire           run_start;
	wire           run_stop;
	wire           res_we;
	wire           seq_done;
	wire           run_clear;
	wire           seq_busy;
	wire           irq_status;
	wire           irq_enable;

	// printed offsets are word indices, so the byte address is four times that
	assign wr_idx = aw_addr_q[AW-1:2];
	assign rd_idx = s_axi_araddr[AW-1:2];

	// decode shared by the write and read paths
	function addr_mapped;
		input [15:0] idx;
		begin
			case (idx)
			`SASQ_IDX_CH6_LOW, `SASQ_IDX_CH6_HIGH,
			`SASQ_IDX_CH7_LOW, `SASQ_IDX_CH7_HIGH,
			`SASQ_IDX_LOOP, `SASQ_IDX_RUN, `SASQ_IDX_MASK,
			`SASQ_IDX_IRQ_STAT, `SASQ_IDX_IRQ_EN,
			`SASQ_IDX_IRQ_CLR, `SASQ_IDX_SEQ_STATE: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel: address and data taken in either order

	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SASQ_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= {AW{1'b0}};
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_q     <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (!aw_have_q && !s_axi_awready && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (!w_have_q && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// read-only targets accept and drop the write
				s_axi_bresp  <= addr_mapped(wr_idx) ? `SASQ_RESP_OKAY : `SASQ_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers

	// the run byte is reached alone or as the upper lane of a 16-bit loop write
	assign run_wr   = wr_fire && (((wr_idx == `SASQ_IDX_RUN) && w_strb_q[0]) ||
	                  ((wr_idx == `SASQ_IDX_LOOP) && w_strb_q[1]));
	assign run_wval = (wr_idx == `SASQ_IDX_RUN) ? w_data_q[`SASQ_RUN_BIT] :
	                  w_data_q[8 + `SASQ_RUN_BIT];
	// an empty mask refuses the start and leaves run at zero
	assign run_start = run_wr && run_wval && !run_bit_q && (|channel_select_mask_q);
	assign run_stop  = run_wr && !run_wval;

	always @* begin
		run_d = run_bit_q;
		if (run_stop) begin
			run_d = 1'b0;
		end else if (run_start) begin
			run_d = 1'b1;
		end else if (run_clear) begin
			run_d = 1'b0;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			continuous_select_q   <= 1'b0;
			run_bit_q             <= 1'b0;
			channel_select_mask_q <= {NCH{1'b0}};
		end else begin
			run_bit_q <= run_d;
			if (wr_fire && (wr_idx == `SASQ_IDX_LOOP) && w_strb_q[0]) begin
				continuous_select_q <= w_data_q[`SASQ_LOOP_BIT];
			end
			if (wr_fire && (wr_idx == `SASQ_IDX_MASK) && w_strb_q[0]) begin
				channel_select_mask_q <= w_data_q[NCH-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// result storage for the two kept channels

	genvar k;
	generate
		for (k = 0; k < `SASQ_KEPT_CH; k = k + 1) begin : g_res
			always @(posedge aclk) begin
				if (!aresetn) begin
					kept_res_q[k] <= {RW{1'b0}};
				end else if (res_we &&
				             (conv_chan == (`SASQ_FIRST_KEPT_CH + k[CW-1:0]))) begin
					kept_res_q[k] <= conv_data;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	always @* begin
		rd_word = 32'h0000_0000;
		case (rd_idx)
		`SASQ_IDX_CH6_LOW: begin
			// upper lane carries the high byte so a 16-bit read gets the pair
			rd_word[7:6]  = kept_res_q[0][1:0];
			rd_word[15:8] = kept_res_q[0][RW-1:2];
		end
		`SASQ_IDX_CH6_HIGH: begin
			rd_word[7:0] = kept_res_q[0][RW-1:2];
		end
		`SASQ_IDX_CH7_LOW: begin
			rd_word[7:6]  = kept_res_q[1][1:0];
			rd_word[15:8] = kept_res_q[1][RW-1:2];
		end
		`SASQ_IDX_CH7_HIGH: begin
			rd_word[7:0] = kept_res_q[1][RW-1:2];
		end
		`SASQ_IDX_LOOP: begin
			rd_word[`SASQ_LOOP_BIT]     = continuous_select_q;
			rd_word[8 + `SASQ_RUN_BIT]  = run_bit_q;
		end
		`SASQ_IDX_RUN: begin
			rd_word[`SASQ_RUN_BIT] = run_bit_q;
		end
		`SASQ_IDX_MASK: begin
			rd_word[NCH-1:0] = channel_select_mask_q;
		end
		`SASQ_IDX_IRQ_STAT: begin
			rd_word[`SASQ_DONE_EVT] = irq_status;
		end
		`SASQ_IDX_IRQ_EN: begin
			rd_word[`SASQ_DONE_EVT] = irq_enable;
		end
		`SASQ_IDX_SEQ_STATE: begin
			rd_word[CW-1:0]        = conv_chan;
			rd_word[`SASQ_BUSY_BIT] = seq_busy;
		end
		default: begin
			rd_word = 32'h0000_0000;
		end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SASQ_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= addr_mapped(rd_idx) ? `SASQ_RESP_OKAY : `SASQ_RESP_SLVERR;
				s_axi_rvalid  <= 1'b1;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer and interrupt

	sasq_seq #(
		.NCH (NCH),
		.CW  (CW)
	) u_seq (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.start        (run_start),
		.stop         (run_stop),
		.loop_sel     (continuous_select_q),
		.mask         (channel_select_mask_q),
		.conv_done    (conv_done),
		.conv_start_q (conv_start),
		.conv_chan_q  (conv_chan),
		.res_we       (res_we),
		.seq_done_q   (seq_done),
		.run_clear_q  (run_clear),
		.busy         (seq_busy)
	);

	sasq_irq #(
		.N (1)
	) u_irq (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.event_in  (seq_done),
		.en_we     (wr_fire && (wr_idx == `SASQ_IDX_IRQ_EN) && w_strb_q[0]),
		.en_wdata  (w_data_q[`SASQ_DONE_EVT]),
		.clr_we    (wr_fire && (wr_idx == `SASQ_IDX_IRQ_CLR) && w_strb_q[0]),
		.clr_wdata (w_data_q[`SASQ_DONE_EVT]),
		.status_q  (irq_status),
		.enable_q  (irq_enable),
		.irq_q     (conversion_done_irq)
	);

	// awprot and arprot carry no meaning for this block
	wire unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot, w_data_q[31:16]};
endmodule // sasq_top

`default_nettype wire

// *** test/sasq_core_model.sv ***
// behavioural converter core facing the sequencer's conv_* pins
// assumes one aclk domain; lat sets the conversion time in cycles
`timescale 1ns/10ps
`default_nettype none

module sasq_core_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        conv_start,
	input  wire logic [2:0]  conv_chan,
	input  wire logic [7:0]  lat,
	input  wire logic [9:0]  res_base,
	output var  logic        conv_done,
	output wire logic [9:0]  conv_data,
	output var  logic [31:0] order,
	output var  logic [7:0]  starts
);
	logic [7:0] cnt_q;
	logic       busy_q;
	logic [9:0] last_q;

	always @(posedge aclk) begin
		conv_done <= 1'b0;
		if (!aresetn) begin
			busy_q <= 1'b0;
			order  <= 32'h0;
			starts <= 8'h0;
			last_q <= 10'h0;
		end else if (conv_start) begin
			busy_q <= 1'b1;
			cnt_q  <= lat;
			order  <= {order[27:0], 1'b0, conv_chan};
			starts <= starts + 8'h1;
		end else if (busy_q && cnt_q == 8'h0) begin
			busy_q    <= 1'b0;
			conv_done <= 1'b1;
			last_q    <= res_base + {7'h0, conv_chan};
		end else if (busy_q) begin
			cnt_q <= cnt_q - 8'h1;
		end
	end

	// data is only valid with done; elsewhere it shows garbage
	assign conv_data = conv_done ? last_q : ~last_q;
endmodule // sasq_core_model
`default_nettype wire

// *** test/sasq_top_monitor.sv ***
// port checker for the sequencer top, bound below
// assumes one aclk domain with synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module sasq_top_monitor #(
	parameter CW = 3
) (
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic [1:0]    s_axi_bresp,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_bready,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_rvalid,
	input wire logic          s_axi_rready,
	input wire logic          conv_start,
	input wire logic [CW-1:0] conv_chan,
	input wire logic          conv_done
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence conv_wait;
		conv_start ##1 !conv_done;
	endsequence

	b_latency_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during data");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	chan_hold_a: assert property (conv_wait |-> $stable(conv_chan))
		else $error("channel moved during conversion");
	start_gap_a: assert property (conv_done |=> !conv_start)
		else $error("start right after done");
endmodule // sasq_top_monitor

bind sasq_top sasq_top_monitor #(.CW(CW)) sasq_top_monitor_inst (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done)
);
`default_nettype wire

// *** test/sasq_top_tb.sv ***
// register-level bench for the sequencer top with a core model
// assumes the register map and bus response codes of sasq_defs.vh
`timescale 1ns/10ps
`default_nettype none
`include "sasq_defs.vh"

module sasq_top_tb;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        conv_start, conv_done, irq;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata, order, rd, err_total, n_checks;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [2:0]  conv_chan;
	logic [9:0]  conv_data, res_base;
	logic [7:0]  lat, starts, k;
	int          i;

	sasq_top sasq_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .conv_start(conv_start), .conv_chan(conv_chan),
		.conv_done(conv_done), .conv_data(conv_data), .conversion_done_irq(irq));
	sasq_core_model sasq_core_model_inst (.aclk(aclk), .aresetn(aresetn),
		.conv_start(conv_start), .conv_chan(conv_chan), .lat(lat), .res_base(res_base),
		.conv_done(conv_done), .conv_data(conv_data), .order(order), .starts(starts));

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("errors %0d checks %0d", err_total, n_checks);
		if (err_total == 0 && n_checks != 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic tmo;
		err_total = err_total + 1;
		print_verdict;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (n == 100) tmo;
	endtask
	task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n == 100) tmo;
		chk(rd, exp);
		chk({30'h0, rs}, {30'h0, `SASQ_RESP_OKAY});
	endtask
	task automatic wchk(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
		wr(idx, d, rs);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	// on_irq waits for the interrupt, otherwise until the model's start count reaches n_st
	task automatic hold(input bit on_irq, input logic [7:0] n_st);
		int n;
		for (n = 0; n < 2000; n++) begin
			@(posedge aclk);
			if (on_irq ? irq === 1'b1 : starts >= n_st) break;
		end
		if (n == 2000) tmo;
	endtask
	function automatic logic [31:0] lo(input logic [9:0] s, input logic [2:0] c);
		logic [9:0] v;
		v = s + {7'h0, c};
		return {16'h0, v, 6'h0};
	endfunction
	function automatic logic [31:0] hi(input logic [9:0] s, input logic [2:0] c);
		logic [9:0] v;
		v = s + {7'h0, c};
		return {24'h0, v[9:2]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 18'h0;
		araddr = 18'h0;
		wdata = 32'h0;
		wstrb = 4'h1;
		res_base = 10'h2c9;
		lat = 8'h3;
		err_total = 0;
		n_checks = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 7; i++) rchk(16'hf2dc + (i < 4 ? i : i + 16), 32'h0);
		wchk(`SASQ_IDX_LOOP, 32'hff, `SASQ_RESP_OKAY);
		rchk(`SASQ_IDX_LOOP, 32'h1);
		wchk(`SASQ_IDX_LOOP, 32'h0, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_MASK, 32'hffa5, `SASQ_RESP_OKAY);
		rchk(`SASQ_IDX_MASK, 32'ha5);
		wchk(`SASQ_IDX_CH6_LOW, 32'hff, `SASQ_RESP_OKAY);
		rchk(`SASQ_IDX_CH6_LOW, 32'h0);
		wchk(16'hf2e8, 32'h1, `SASQ_RESP_SLVERR);
		// run with nothing selected must do nothing
		wchk(`SASQ_IDX_MASK, 32'h0, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_RUN, 32'h1, `SASQ_RESP_OKAY);
		rchk(`SASQ_IDX_RUN, 32'h0);
		chk({24'h0, starts}, 32'h0);
		// single pass over 0, 6, 7; mask edit mid-run is ignored
		wchk(`SASQ_IDX_IRQ_EN, 32'h1, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_MASK, 32'hc1, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_RUN, 32'h1, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_MASK, 32'h1, `SASQ_RESP_OKAY);
		hold(1, 0);
		chk(order, 32'h067);
		rchk(`SASQ_IDX_RUN, 32'h0);
		rchk(`SASQ_IDX_IRQ_STAT, 32'h1);
		rchk(`SASQ_IDX_IRQ_EN, 32'h1);
		rchk(`SASQ_IDX_CH6_LOW, lo(res_base, 6));
		rchk(`SASQ_IDX_CH6_HIGH, hi(res_base, 6));
		rchk(`SASQ_IDX_CH7_LOW, lo(res_base, 7));
		rchk(`SASQ_IDX_CH7_HIGH, hi(res_base, 7));
		wchk(`SASQ_IDX_IRQ_CLR, 32'h1, `SASQ_RESP_OKAY);
		rchk(`SASQ_IDX_IRQ_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// continuous mode keeps restarting until stopped
		res_base = 10'h155;
		wchk(`SASQ_IDX_LOOP, 32'h1, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_MASK, 32'h40, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_RUN, 32'h1, `SASQ_RESP_OKAY);
		hold(0, 8'd6);
		rchk(`SASQ_IDX_RUN, 32'h1);
		wchk(`SASQ_IDX_RUN, 32'h0, `SASQ_RESP_OKAY);
		rchk(`SASQ_IDX_RUN, 32'h0);
		k = starts;
		repeat (40) @(posedge aclk);
		chk({24'h0, starts}, {24'h0, k});
		rchk(`SASQ_IDX_CH6_HIGH, hi(res_base, 6));
		// stop in mid-conversion: no result, no interrupt
		wchk(`SASQ_IDX_LOOP, 32'h0, `SASQ_RESP_OKAY);
		wchk(`SASQ_IDX_IRQ_CLR, 32'h1, `SASQ_RESP_OKAY);
		res_base = 10'h3a4;
		lat = 8'd30;
		wchk(`SASQ_IDX_MASK, 32'hc0, `SASQ_RESP_OKAY);
		k = starts;
		wchk(`SASQ_IDX_RUN, 32'h1, `SASQ_RESP_OKAY);
		hold(0, k + 8'h1);
		wchk(`SASQ_IDX_RUN, 32'h0, `SASQ_RESP_OKAY);
		repeat (60) @(posedge aclk);
		rchk(`SASQ_IDX_CH6_HIGH, hi(10'h155, 6));
		rchk(`SASQ_IDX_CH7_HIGH, hi(10'h2c9, 7));
		rchk(`SASQ_IDX_SEQ_STATE, 32'h6);
		rchk(`SASQ_IDX_IRQ_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		print_verdict;
	end
endmodule // sasq_top_tb
`default_nettype wire
